// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the result slot register file
// Assumes: Zero-wait APB slave; word accesses only; offsets from the package
// Notes: Table loop covers capture and flags; hand tests cover the rest

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  adc_result_pkg::conv_wr_s [2:0] conv_wr;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [11:0] ofs [3] = '{adc_result_pkg::OFS_SLOT5, adc_result_pkg::OFS_SLOT6,
    adc_result_pkg::OFS_SLOT7};
  int row_k [4] = '{0, 1, 2, 0};
  logic [9:0] row_v [4] = '{10'h3ff, 10'h001, 10'h2aa, 10'h155};
  logic [31:0] row_x [4] = '{32'h0000_ffc1, 32'h0000_0041, 32'h0000_aa81, 32'h0000_5541};

  adc_result_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_wr(conv_wr), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard, well above the hundred or so cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk1

  ////////////////////////////////////////////////////////////////////////////
  // Always full word transfers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hf;
    @(posedge pclk);
    chk1(pready, 1'b0, "ready in setup");
    penable <= 1'b1;
    @(posedge pclk);
    // Only pready or the hang guard ends this wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chk32(rd, exp, msg);
  endtask : rd_chk

  // Static so the lane index may steer a nonblocking write
  task conv(input int k, input logic [9:0] v);
    @(posedge pclk);
    conv_wr[k] <= {1'b1, v};
    @(posedge pclk);
    conv_wr[k] <= '0;
    #1;
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    conv_wr = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      rd_chk(ofs[k], adc_result_pkg::SLOT_RESET, "slot after reset");
    end
    chk1(irq, 1'b0, "irq after reset");
    for (int i = 0; i < 4; i++) begin
      conv(row_k[i], row_v[i]);
      rd_chk(ofs[row_k[i]], row_x[i], "slot capture");
      rd_chk(ofs[row_k[i]], row_x[i] & 32'hffff_fffc, "flags cleared");
    end
    // Events seen while masked: status set, irq low
    rd_chk(adc_result_pkg::OFS_IRQ_STATUS, 32'h0000_0007, "status masked");
    chk1(irq, 1'b0, "irq masked");
    apb(1'b1, adc_result_pkg::OFS_IRQ_ENABLE, 32'h0000_003f, rd, er);
    #1;
    chk1(irq, 1'b1, "irq enabled");
    apb(1'b1, adc_result_pkg::OFS_IRQ_CLEAR, 32'h0000_003f, rd, er);
    #1;
    chk1(irq, 1'b0, "irq cleared");
    rd_chk(adc_result_pkg::OFS_IRQ_CLEAR, 32'h0000_0000, "clear reads zero");
    // Overrun: two results before one read
    conv(2, 10'h0f0);
    conv(2, 10'h30f);
    chk1(irq, 1'b1, "irq on result");
    rd_chk(adc_result_pkg::OFS_IRQ_STATUS, 32'h0000_0024, "status overrun");
    rd_chk(ofs[2], 32'h0000_c3c3, "overrun set");
    rd_chk(ofs[2], 32'h0000_c3c0, "overrun cleared");
    // Simultaneous results on all slots in one cycle
    @(posedge pclk);
    conv_wr <= {{1'b1, 10'h200}, {1'b1, 10'h100}, {1'b1, 10'h080}};
    @(posedge pclk);
    conv_wr <= '0;
    rd_chk(ofs[0], 32'h0000_2001, "slot5 parallel");
    rd_chk(ofs[1], 32'h0000_4001, "slot6 parallel");
    rd_chk(ofs[2], 32'h0000_8001, "slot7 parallel");
    // Refused accesses
    apb(1'b0, 12'h018, 32'h0000_0000, rd, er);
    chk1(er, 1'b1, "unmapped error");
    chk32(rd, 32'h0000_0000, "unmapped data");
    apb(1'b1, ofs[0], 32'hffff_ffff, rd, er);
    chk1(er, 1'b1, "slot write error");
    rd_chk(ofs[0], 32'h0000_2000, "slot write ignored");
    // Second reset in mid-run
    conv(1, 10'h3ff);
    conv(1, 10'h155);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk1(irq, 1'b0, "irq after second reset");
    rd_chk(ofs[1], adc_result_pkg::SLOT_RESET, "slot after second reset");
    rd_chk(adc_result_pkg::OFS_IRQ_ENABLE, 32'h0000_0000, "enable after reset");
    tally_and_finish();
  end

endmodule : tb_top

// ---- design/adc_result_regs.sv ----
// Purpose: APB register file for conversion result slots 5, 6 and 7
// Assumes: APB master keeps psel, paddr, pwrite stable through access
// Notes: Reads are captured and cleared at the setup edge, one wait-free
//   access phase follows; interrupt status/enable/clear sit after slots
//
// Implementation choices: the APB interface to the registers and the placing of the registers.

////////////////////////////////////////////////////////////////////////////
module adc_result_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adc_result_pkg::conv_wr_s [2:0] conv_wr,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] slot_word(input adc_result_pkg::slot_s s);
    logic [31:0] w;
    w = adc_result_pkg::SLOT_RESET;
    w[adc_result_pkg::VALUE_MSB:adc_result_pkg::VALUE_LSB] = s.value;
    w[adc_result_pkg::OVERRUN_BIT] = s.overrun;
    w[adc_result_pkg::STORED_BIT] = s.stored;
    return w;
  endfunction : slot_word

  function automatic logic [2:0] slot_hit(input logic [11:0] a);
    logic [2:0] h;
    h = 3'h0;
    h[0] = (a == adc_result_pkg::OFS_SLOT5);
    h[1] = (a == adc_result_pkg::OFS_SLOT6);
    h[2] = (a == adc_result_pkg::OFS_SLOT7);
    return h;
  endfunction : slot_hit

  function automatic logic addr_known(input logic [11:0] a);
    return (|slot_hit(a)) || (a == adc_result_pkg::OFS_IRQ_STATUS)
      || (a == adc_result_pkg::OFS_IRQ_ENABLE)
      || (a == adc_result_pkg::OFS_IRQ_CLEAR);
  endfunction : addr_known

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  adc_result_pkg::slot_s [2:0] slot;
  logic [2:0] stored_evt;
  logic [2:0] overrun_evt;
  logic [2:0] rd_clr;
  logic setup_cyc;
  logic acc_done;
  logic wr_done;
  adc_result_pkg::apb_phase_e phase_r;
  adc_result_pkg::apb_phase_e phase_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [5:0] status_r;
  logic [5:0] status_nxt;
  logic [5:0] enable_r;
  logic [5:0] enable_nxt;
  logic [5:0] clr_mask;
  logic irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Slots

  for (genvar k = 0; k < 3; k++) begin : g_slot
    result_slot u_slot (
      .pclk(pclk),
      .presetn(presetn),
      .conv_wr(conv_wr[k]),
      .rd_clr(rd_clr[k]),
      .slot(slot[k]),
      .stored_evt(stored_evt[k]),
      .overrun_evt(overrun_evt[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB phase tracking
  // Read data is captured at the setup edge so the access phase needs no
  // wait state; the read side effect is taken at the same edge to stay
  // coherent with what software sees.

  assign setup_cyc = psel & ~penable;
  assign acc_done = psel & penable & pready;
  assign wr_done = acc_done & pwrite & addr_known(paddr);
  assign rd_clr = (setup_cyc && !pwrite) ? slot_hit(paddr) : 3'h0;

  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      adc_result_pkg::ph_idle: begin
        if (setup_cyc) begin
          phase_nxt = adc_result_pkg::ph_capt;
        end
      end
      adc_result_pkg::ph_capt: begin
        if (psel && penable) begin
          phase_nxt = adc_result_pkg::ph_done;
        end else if (!psel) begin
          phase_nxt = adc_result_pkg::ph_idle;
        end
      end
      adc_result_pkg::ph_done: begin
        phase_nxt = setup_cyc ? adc_result_pkg::ph_capt : adc_result_pkg::ph_idle;
      end
      default: begin
        phase_nxt = adc_result_pkg::ph_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= adc_result_pkg::ph_idle;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign pready = penable & (phase_r == adc_result_pkg::ph_capt);
  // Writes to the read-only slots are refused, like unmapped addresses
  assign pslverr = pready & (~addr_known(paddr) | (pwrite & (|slot_hit(paddr))));

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_cyc && !pwrite) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        adc_result_pkg::OFS_SLOT5: prdata_nxt = slot_word(slot[0]);
        adc_result_pkg::OFS_SLOT6: prdata_nxt = slot_word(slot[1]);
        adc_result_pkg::OFS_SLOT7: prdata_nxt = slot_word(slot[2]);
        adc_result_pkg::OFS_IRQ_STATUS: prdata_nxt = {26'h0, status_r};
        adc_result_pkg::OFS_IRQ_ENABLE: prdata_nxt = {26'h0, enable_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= adc_result_pkg::SLOT_RESET;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and write-one-to-clear
  // Only byte lane 0 carries the six bits; other lanes are ignored.

  always_comb begin
    clr_mask = 6'h00;
    if (wr_done && paddr == adc_result_pkg::OFS_IRQ_CLEAR && pstrb[0]) begin
      clr_mask = pwdata[5:0];
    end
  end

  always_comb begin
    status_nxt = status_r & ~clr_mask;
    status_nxt[adc_result_pkg::IRQ_STORED_LSB +: 3] =
      status_nxt[adc_result_pkg::IRQ_STORED_LSB +: 3] | stored_evt;
    status_nxt[adc_result_pkg::IRQ_OVERRUN_LSB +: 3] =
      status_nxt[adc_result_pkg::IRQ_OVERRUN_LSB +: 3] | overrun_evt;
  end

  always_comb begin
    enable_nxt = enable_r;
    if (wr_done && paddr == adc_result_pkg::OFS_IRQ_ENABLE && pstrb[0]) begin
      enable_nxt = pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= adc_result_pkg::IRQ_STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= adc_result_pkg::IRQ_ENABLE_RESET;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // Registered so the line tracks status and enable exactly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & enable_nxt);
    end
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_cyc && !pwrite && (|slot_hit(paddr)))
      |=> (prdata[31:16] == 16'h0000) && (prdata[5:2] == 4'h0))
    else $error("reserved bits of a slot read back nonzero");

  AST_RESET_ZERO: assert property (@(posedge pclk)
    $rose(presetn) |-> (slot_word(slot[0]) == 32'h0) && (slot_word(slot[1]) == 32'h0)
      && (slot_word(slot[2]) == 32'h0) && (prdata == 32'h0))
    else $error("slot registers not zero after reset");

  AST_FIELD_PLACE: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_cyc && !pwrite && paddr == adc_result_pkg::OFS_SLOT6)
      |=> prdata[15:6] == $past(slot[1].value))
    else $error("result field misplaced in read data");

  AST_READ_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_cyc && !pwrite && paddr == adc_result_pkg::OFS_SLOT7)
      |=> prdata[1:0] == {$past(slot[2].overrun), $past(slot[2].stored)})
    else $error("flags in read data do not match slot state");

  AST_STORED_SET: assert property (@(posedge pclk) disable iff (!presetn)
    conv_wr[0].valid |=> slot[0].stored && status_r[adc_result_pkg::IRQ_STORED_LSB])
    else $error("stored flag or status not set by result");

  AST_READ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_cyc && !pwrite && paddr == adc_result_pkg::OFS_SLOT5 && !conv_wr[0].valid)
      |=> !slot[0].stored && !slot[0].overrun)
    else $error("slot read did not clear its flags");

  AST_OVERRUN_NEEDS_STORED: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(slot[1].overrun) |-> $past(slot[1].stored) && $past(conv_wr[1].valid))
    else $error("overrun without unread result");

  AST_NO_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    setup_cyc ##1 (psel && penable) |-> pready)
    else $error("access phase not answered at once");

  // A clear or enable write in the next cycle may lawfully drop the line again
  AST_IRQ_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    (overrun_evt[2] && enable_r[5] && !(wr_done && paddr == adc_result_pkg::OFS_IRQ_ENABLE))
      |=> irq ##1 (irq || $past(wr_done)))
    else $error("enabled overrun did not raise interrupt");

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer and interrupt register checks

  AST_READY_IN_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable)
    else $error("ready raised outside an access phase");

  AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");

  AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !addr_known(paddr)) |-> pslverr)
    else $error("unmapped access not refused");

  AST_ERR_SLOT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && pwrite && (|slot_hit(paddr))) |-> pslverr)
    else $error("write to a result slot not refused");

  AST_NO_ERR_MAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && addr_known(paddr) && !(pwrite && (|slot_hit(paddr)))) |-> !pslverr)
    else $error("legal access answered with error");

  AST_SLOT_WRITE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && (|slot_hit(paddr)) && !conv_wr[0].valid && !conv_wr[1].valid
      && !conv_wr[2].valid) |=> slot == $past(slot))
    else $error("refused slot write changed a slot");

  // Software may read the word late, so it must not move between reads
  AST_PRDATA_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    !(setup_cyc && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");

  AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_cyc && !pwrite && paddr == adc_result_pkg::OFS_IRQ_STATUS)
      |=> prdata == {26'h0, $past(status_r)})
    else $error("status read back wrong");

  AST_ENABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && paddr == adc_result_pkg::OFS_IRQ_ENABLE && pstrb[0])
      |=> enable_r == $past(pwdata[5:0]))
    else $error("enable write did not land");

  AST_STATUS_CLEARED: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && paddr == adc_result_pkg::OFS_IRQ_CLEAR && pstrb[0]
      && !(|stored_evt) && !(|overrun_evt))
      |=> (status_r & $past(pwdata[5:0])) == 6'h00)
    else $error("clear write left status bits set");

  // Sticky: only a clear write may drop a status bit
  AST_STATUS_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_done && paddr == adc_result_pkg::OFS_IRQ_CLEAR)
      |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status bit dropped without a clear");

  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (|(status_r & enable_r)))
    else $error("interrupt line does not match enabled status");

  AST_OVERRUN_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_evt[2] |=> status_r[adc_result_pkg::IRQ_OVERRUN_LSB + 2])
    else $error("overrun did not reach status");

  AST_STORED_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    conv_wr[2].valid |=> status_r[adc_result_pkg::IRQ_STORED_LSB + 2])
    else $error("stored event did not reach status");

  AST_CLR_ONE_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(rd_clr))
    else $error("read clears more than one slot");

  AST_PHASE_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
    phase_r != 2'b10)
    else $error("bus phase tracker in unused code");

  AST_DATA_ZERO_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_cyc && !pwrite && !addr_known(paddr))
      |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

endmodule : adc_result_regs

// ---- design/result_slot.sv ----
// Purpose: One conversion result slot with overrun and stored flags
// Assumes: Writes and read-clears arrive as one-cycle pulses on pclk
// Notes: A result landing with a read-clear is kept as unread

module result_slot (
  input wire logic pclk,
  input wire logic presetn,
  input wire adc_result_pkg::conv_wr_s conv_wr,
  input wire logic rd_clr,
  output adc_result_pkg::slot_s slot,
  output logic stored_evt,
  output logic overrun_evt
);

  logic [9:0] value_r;
  logic overrun_r;
  logic stored_r;

  ////////////////////////////////////////////////////////////////////////////
  // A write that coincides with the read is not an overrun: the read took
  // the old value.
  assign stored_evt = conv_wr.valid;
  assign overrun_evt = conv_wr.valid & stored_r & ~rd_clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= adc_result_pkg::VALUE_RESET;
    end else if (conv_wr.valid) begin
      value_r <= conv_wr.value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_r <= 1'b0;
    end else if (overrun_evt) begin
      overrun_r <= 1'b1;
    end else if (rd_clr) begin
      overrun_r <= 1'b0;
    end
  end

  // Set wins over the read-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_r <= 1'b0;
    end else if (conv_wr.valid) begin
      stored_r <= 1'b1;
    end else if (rd_clr) begin
      stored_r <= 1'b0;
    end
  end

  assign slot = '{value: value_r, overrun: overrun_r, stored: stored_r};

  ////////////////////////////////////////////////////////////////////////////
  AST_VALUE_LOADS: assert property (@(posedge pclk) disable iff (!presetn)
    conv_wr.valid |=> (value_r == $past(conv_wr.value)) && stored_r)
    else $error("slot value not loaded from converter");

  AST_OVERRUN_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_wr.valid && stored_r && !rd_clr) |=> overrun_r)
    else $error("overwrite of unread result did not flag overrun");

  AST_OVERRUN_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    rd_clr |=> !overrun_r)
    else $error("overrun flag not cleared by read");

  AST_STORED_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_clr && !conv_wr.valid) |=> !stored_r ##1 (stored_r == $past(conv_wr.valid)))
    else $error("stored flag not cleared by read");

endmodule : result_slot

// ---- inc/adc_result_pkg.sv ----
// Purpose: Shared constants and types for the conversion result slots 5..7
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Offsets below are byte addresses

package adc_result_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned NUM_SLOTS = 3;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IRQ_W = 6;

  localparam logic [11:0] OFS_SLOT5 = 12'h000;
  localparam logic [11:0] OFS_SLOT6 = 12'h004;
  localparam logic [11:0] OFS_SLOT7 = 12'h008;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h010;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h014;

  localparam int unsigned VALUE_LSB = 6;
  localparam int unsigned VALUE_MSB = 15;
  localparam int unsigned OVERRUN_BIT = 1;
  localparam int unsigned STORED_BIT = 0;
  localparam int unsigned IRQ_STORED_LSB = 0;
  localparam int unsigned IRQ_OVERRUN_LSB = 3;

  localparam logic [31:0] SLOT_RESET = 32'h0000_0000;
  localparam logic [9:0] VALUE_RESET = 10'h000;
  localparam logic [5:0] IRQ_STATUS_RESET = 6'h00;
  localparam logic [5:0] IRQ_ENABLE_RESET = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic valid;
    logic [9:0] value;
  } conv_wr_s;

  typedef struct packed {
    logic [9:0] value;
    logic overrun;
    logic stored;
  } slot_s;

  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_capt = 2'b01,
    ph_done = 2'b11
  } apb_phase_e;

endpackage : adc_result_pkg
